// >>> hw/wake_pkg.sv
// Package for the key wake-up port block: register map, field positions,
// reset values and filter timing.
// Assumes a 32-bit APB slave on a 20 MHz clock.
package wake_pkg;
	// Register byte offsets on the APB
	localparam logic [7:0] off_g_flags = 8'h00; // Port G wake flags, W1C
	localparam logic [7:0] off_h_flags = 8'h04; // Port H wake flags, W1C
	localparam logic [7:0] off_g_enables = 8'h08; // Port G enables and I2C select
	localparam logic [7:0] off_h_enables = 8'h0c; // Port H enables
	localparam logic [7:0] off_stop = 8'h10; // Stop and wait request bits
	localparam logic [7:0] off_irq_status = 8'h14; // Sticky event status, read only
	localparam logic [7:0] off_irq_clear = 8'h18; // Write one to clear status
	localparam logic [7:0] off_irq_enable = 8'h1c; // Status enable mask
	// Field positions
	localparam int flag_six_pos = 6; // Port G bit that can report an I2C start
	localparam int pin_seven_pos = 7; // Port G bit without wake-up
	localparam int stop_bit = 0; // Stop mode request
	localparam int wait_bit = 1; // Wait mode request
	localparam int ev_wake_bit = 0; // Status: wake-up interrupt raised
	localparam int ev_exit_bit = 1; // Status: low-power mode left
	// Reset values
	localparam logic [7:0] flags_reset = 8'h00; // All flags clear
	localparam logic [7:0] enables_reset = 8'h00; // All wake-ups disabled
	localparam logic [7:0] g_flag_mask = 8'h7f; // Bit 7 reads zero
	// Least pulse width that wakes from stop, in ns
	localparam int filter_ns = 200;
	localparam int clock_ns = 50;
	localparam int filter_cycles = (filter_ns + clock_ns - 1) / clock_ns;
	localparam int filter_width = 4;
endpackage

// >>> hw/wake_filter.sv
// Pulse filter for one wake-up pin: a low level must persist for a
// set number of cycles before the filtered output falls.
// Assumes pin levels are already synchronous to clock.
`timescale 1ns/1ns
module wake_filter (
	input wire logic clock, // System clock
	input wire logic reset, // Synchronous reset, active high
	input wire logic pin, // Raw pin level
	output logic level // Filtered pin level
);
	import wake_pkg::*;
	logic [filter_width-1:0] count; // Cycles the pin has disagreed
	logic [filter_width-1:0] next_count;
	logic next_level;

	// A disagreement must last filter_cycles before the output follows
	always_comb begin
		next_count = count;
		next_level = level;
		if (pin == level) begin
			next_count = '0;
		end else if (count == filter_width'(filter_cycles - 1)) begin
			next_count = '0;
			next_level = pin;
		end else begin
			next_count = count + filter_width'(1);
		end
	end

	// Register; idle pins are high, so reset to high avoids a false edge
	always_ff @(posedge clock) begin
		if (reset) begin
			count <= '0;
			level <= 1'b1;
		end else begin
			count <= next_count;
			level <= next_level;
		end
	end
endmodule

// >>> hw/key_wakeup_port.sv
// Key wake-up logic for two 8-bit ports with APB registers.
// Assumes pins synchronous to clock, one 20 MHz clock, synchronous reset.
`timescale 1ns/1ns
// How it works
// - sixteen pins, fifteen with wake-up
// - falling edge sets flag, rising does not
// - flag and enable raise the interrupt
// - all pins share one interrupt line
// - writing one clears, zero keeps
// - port G bit seven reads zero
// - G bit six: edge or I2C start
// - interrupt leaves stop and wait
// - stop path runs on clock, through the filter
// - filter rejects short pulses in stop
// - works for inputs and outputs alike
module key_wakeup_port (
	input wire logic clock, // System clock, 20 MHz
	input wire logic reset, // Synchronous reset, active high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error for unmapped address
	input wire logic [7:0] port_g_pins, // Port G pin levels, input or output
	input wire logic [7:0] port_h_pins, // Port H pin levels, input or output
	input wire logic i2c_start, // One-cycle pulse: I2C start seen
	output logic wake_irq, // Shared key wake-up interrupt request
	output logic stop_mode, // Processor is stopped
	output logic wait_mode, // Processor is waiting
	output logic event_irq // Status interrupt, level
);
	import wake_pkg::*;

	logic [15:0] pins; // Both ports, G low
	logic [15:0] filt; // Filtered levels used while stopped
	logic [15:0] prev; // Previous sampled level
	logic [15:0] flags; // Wake flags, G low
	logic [15:0] enables; // Wake enables, G low
	logic [15:0] next_flags;
	logic [15:0] next_enables;
	logic [15:0] fall; // Falling edges this cycle
	logic [15:0] next_prev;
	logic next_stop, next_wait, next_wake;
	logic [1:0] status, irq_en, next_status, next_irq_en;
	logic next_event;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic setup, wr, rd, unmapped;
	logic write_ok; // Write to a mapped register, may change state

	assign pins = {port_h_pins, port_g_pins};

	// One filter per pin; raw level in normal run, filtered level in stop
	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : g_pin
			wake_filter u_filter (
				.clock(clock),
				.reset(reset),
				.pin(pins[i]),
				.level(filt[i])
			);
			// Falling edge detect; rising edges are ignored
			assign next_prev[i] = stop_mode ? filt[i] : pins[i];
			assign fall[i] = prev[i] & ~next_prev[i];
		end
	endgenerate

	// A setup phase answers in the access cycle after it
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite & pready;
	assign rd = setup & ~pwrite;
	assign unmapped = paddr > off_irq_enable || paddr[1:0] != 2'b00;

	// Only a mapped write at the access edge may change state
	assign write_ok = wr & ~pslverr;

	// Enable registers; G bit 7 selects the source of flag six
	always_comb begin
		next_enables = enables;
		if (write_ok && paddr == off_g_enables) begin
			next_enables[7:0] = pwdata[7:0];
		end
		if (write_ok && paddr == off_h_enables) begin
			next_enables[15:8] = pwdata[7:0];
		end
	end

	// Flags: clear by writing one, zero bits leave flags alone
	always_comb begin
		next_flags = flags;
		if (write_ok && paddr == off_g_flags) begin
			next_flags[7:0] = flags[7:0] & ~pwdata[7:0];
		end
		if (write_ok && paddr == off_h_flags) begin
			next_flags[15:8] = flags[15:8] & ~pwdata[7:0];
		end
		// Set wins over a clear in the same cycle, so no edge is lost
		next_flags[5:0] = next_flags[5:0] | fall[5:0];
		// Bit 7 has no wake-up as a pin; its enable bit picks bit six's source
		next_flags[flag_six_pos] = next_flags[flag_six_pos] |
			(enables[pin_seven_pos] ? i2c_start : fall[flag_six_pos]);
		next_flags[pin_seven_pos] = 1'b0;
		next_flags[15:8] = next_flags[15:8] | fall[15:8];
		// One shared request line for all fifteen wake-up pins
		next_wake = |(next_flags & {next_enables[15:8], 1'b0, next_enables[6:0]});
	end

	// Mode bits: software enters stop or wait, any wake request leaves both
	always_comb begin
		next_stop = stop_mode;
		next_wait = wait_mode;
		if (write_ok && paddr == off_stop) begin
			next_stop = pwdata[stop_bit];
			next_wait = pwdata[wait_bit];
		end
		// A pending wake wins over software asking for low power
		if (next_wake) begin
			next_stop = 1'b0;
			next_wait = 1'b0;
		end
	end

	// Sticky status; a new event wins over a clear in the same cycle
	always_comb begin
		next_status = status;
		next_irq_en = irq_en;
		if (write_ok && paddr == off_irq_clear) begin
			next_status = status & ~pwdata[1:0];
		end
		if (write_ok && paddr == off_irq_enable) begin
			next_irq_en = pwdata[1:0];
		end
		if (next_wake && !wake_irq) begin
			next_status[ev_wake_bit] = 1'b1;
		end
		if ((stop_mode || wait_mode) && next_wake) begin
			next_status[ev_exit_bit] = 1'b1;
		end
		next_event = |(next_status & next_irq_en);
	end

	// APB read data
	always_comb begin
		next_prdata = 32'h0000_0000;
		next_pready = setup;
		next_pslverr = setup & unmapped;
		if (rd) begin
			unique case (paddr)
				off_g_flags: next_prdata[7:0] = flags[7:0] & g_flag_mask;
				off_h_flags: next_prdata[7:0] = flags[15:8];
				off_g_enables: next_prdata[7:0] = enables[7:0];
				off_h_enables: next_prdata[7:0] = enables[15:8];
				off_stop: next_prdata[1:0] = {wait_mode, stop_mode};
				off_irq_status: next_prdata[1:0] = status;
				off_irq_enable: next_prdata[1:0] = irq_en;
				default: ;
			endcase
		end
	end

	// Flag and edge state; prev starts high so idle pins give no edge after reset
	always_ff @(posedge clock) begin
		if (reset) begin
			flags <= {flags_reset, flags_reset};
			enables <= {enables_reset, enables_reset};
			prev <= 16'hffff;
			wake_irq <= 1'b0;
		end else begin
			flags <= next_flags;
			enables <= next_enables;
			prev <= next_prev;
			wake_irq <= next_wake;
		end
	end

	// Low-power mode bits
	always_ff @(posedge clock) begin
		if (reset) begin
			stop_mode <= 1'b0;
			wait_mode <= 1'b0;
		end else begin
			stop_mode <= next_stop;
			wait_mode <= next_wait;
		end
	end

	// Sticky event status, its mask and its interrupt
	always_ff @(posedge clock) begin
		if (reset) begin
			status <= 2'h0;
			irq_en <= 2'h0;
			event_irq <= 1'b0;
		end else begin
			status <= next_status;
			irq_en <= next_irq_en;
			event_irq <= next_event;
		end
	end

	// Bus answer; it stands for the access cycle only
	always_ff @(posedge clock) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// Checks
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	// A falling edge on port G pin 0 leaves its flag set one cycle later
	fall_sets_flag_a: assert property (
		fall[0] |=> flags[0]) else $error("Falling edge did not set flag");

	// A rise on a pin whose flag is clear must not set it
	rise_no_flag_a: assert property (
		$rose(pins[2]) && !stop_mode && !flags[2] && !fall[2] |=> !flags[2])
		else $error("Rising edge set a flag");

	// The shared request mirrors flag and enable, bit 7 excluded
	irq_follows_a: assert property (
		|(flags & enables & 16'hff7f) == wake_irq) else $error("Interrupt mismatch");

	// Bit 7 of port G never holds a flag
	bit_seven_zero_a: assert property (
		!flags[pin_seven_pos]) else $error("Bit seven set");

	// A read of port G flags always shows bit 7 low
	read_seven_zero_a: assert property (
		pready && !pwrite && paddr == off_g_flags |-> !prdata[pin_seven_pos])
		else $error("Bit seven read as one");

	// With the I2C source selected, a start sets flag six
	i2c_select_a: assert property (
		enables[pin_seven_pos] && i2c_start |=> flags[flag_six_pos])
		else $error("I2C start not flagged");

	// With the I2C source selected, the pin edge is ignored
	i2c_masks_edge_a: assert property (
		enables[pin_seven_pos] && !i2c_start && !flags[6] && !wr |=> !flags[6])
		else $error("Edge flagged in I2C mode");

	// With the pin source selected, a fall on pin six sets flag six
	pin_six_edge_a: assert property (
		!enables[pin_seven_pos] && fall[flag_six_pos] |=> flags[flag_six_pos])
		else $error("Pin six edge not flagged");

	// A raised request has already ended stop and wait
	wake_exits_a: assert property (
		wake_irq |-> !stop_mode && !wait_mode) else $error("Still in low power");

	// Writing zero keeps a set flag
	zero_write_keeps_a: assert property (
		wr && paddr == off_g_flags && !pwdata[0] && flags[0] |=> flags[0])
		else $error("Zero write cleared flag");

	// Writing one clears a flag unless a new edge arrives with it
	g_clear_a: assert property (
		wr && !pslverr && paddr == off_g_flags && pwdata[0] && !fall[0] |=> !flags[0])
		else $error("Port G flag not cleared");

	// Port H clears like port G
	h_clear_a: assert property (
		wr && paddr == off_h_flags && pwdata[3] && !fall[11] |=> !flags[11])
		else $error("Port H flag not cleared");

	// Port H edges set flags like port G
	h_fall_sets_a: assert property (
		fall[11] |=> flags[11]) else $error("Port H edge did not set flag");

	// While stopped, a pulse the filter holds back changes no flag
	filter_blocks_a: assert property (
		stop_mode && (&filt) && !i2c_start && !wr |=> flags == $past(flags))
		else $error("Short pulse reached a flag");

	// The bus answer stands for one cycle only
	ready_one_cycle_a: assert property (
		pready |=> !pready) else $error("Ready held too long");

	// An error answer only comes with ready
	slverr_ready_a: assert property (
		pslverr |-> pready) else $error("Error without ready");

	// A status bit stays set until software clears it
	status_sticky_a: assert property (
		status[ev_wake_bit] && !(wr && paddr == off_irq_clear) |=> status[ev_wake_bit])
		else $error("Status bit lost");

	// The status interrupt mirrors status and mask
	event_follows_a: assert property (
		event_irq == |(status & irq_en)) else $error("Status interrupt mismatch");

	// Main scenarios: stop and wait exits, I2C start, clear, unmapped access
	wake_cover_c: cover property (stop_mode ##[1:20] wake_irq);
	i2c_cover_c: cover property (enables[7] && i2c_start ##1 flags[6]);
	clear_cover_c: cover property (wr && paddr == off_g_flags && |flags[7:0]);
	wait_cover_c: cover property (wait_mode ##[1:20] wake_irq);
	error_cover_c: cover property (pslverr);
endmodule

// >>> tb/pin_model.sv
// Model of the far side: the wires that drive both key wake-up ports.
// Assumes the bench calls its tasks one at a time, from just after an edge.
`timescale 1ns/1ns
module pin_model (
	input wire logic clock, // System clock
	output logic [15:0] pins, // Port H in [15:8], port G in [7:0]
	output logic i2c_start // Start condition pulse
);
	// A pull-up holds every pin high, so no level is left to chance
	initial begin
		pins = 16'hffff;
		i2c_start = 1'b0;
	end
	// Pull one pin low for len cycles, then let the pull-up take it back
	task automatic pulse(input int idx, input int len);
		@(posedge clock);
		pins[idx] <= 1'b0;
		repeat (len) @(posedge clock);
		pins[idx] <= 1'b1;
	endtask
	// One-cycle start condition
	task automatic start_cond();
		@(posedge clock);
		i2c_start <= 1'b1;
		@(posedge clock);
		i2c_start <= 1'b0;
	endtask
endmodule

// >>> tb/testbench.sv
// Bench for the key wake-up port: APB tasks and directed tests.
// Assumes the pin model idles every pin high between pulses.
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench;
	import wake_pkg::*;
	logic clock, reset, psel, penable, pwrite, pready, pslverr, e; // Clock, reset, APB
	logic [7:0] paddr; // APB address
	logic [31:0] pwdata, prdata, q; // APB data and last read data
	logic [15:0] pins; // Port H high byte, port G low byte
	logic i2c_start, wake_irq, stop_mode, wait_mode, event_irq; // Events and modes
	int n_errors = 0, checked = 0, cycles = 0; // Counters
	key_wakeup_port dut (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .port_g_pins(pins[7:0]), .port_h_pins(pins[15:8]), .i2c_start,
		.wake_irq, .stop_mode, .wait_mode, .event_irq);
	pin_model pm (.clock, .pins, .i2c_start);
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Ceiling far above the directed run, so a hang cannot pass
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic summarize();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// One APB transfer; the request stands until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// Wait for the answer however long it takes; only the bench timeout ends this
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		`CHK(q, x)
	endtask
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		// Reset values
		rd(off_g_flags, {24'h0, flags_reset});
		rd(off_h_enables, {24'h0, enables_reset});
		`CHK(wake_irq, 1'b0)
		// Falling edge sets; zero keeps, one clears
		pm.pulse(0, 6);
		rd(off_g_flags, 32'h01);
		wr(off_g_flags, 32'h0);
		rd(off_g_flags, 32'h01);
		wr(off_g_flags, 32'h01);
		rd(off_g_flags, 32'h00);
		// A rising edge after the clear must not set the flag again
		fork
			pm.pulse(2, 16);
			begin
				repeat (6) @(posedge clock);
				wr(off_g_flags, 32'h04);
			end
		join
		rd(off_g_flags, 32'h00);
		pm.pulse(pin_seven_pos, 6);
		rd(off_g_flags, 32'h00);
		// Port H raises the shared line
		wr(off_h_enables, 32'h08);
		pm.pulse(11, 6);
		rd(off_h_flags, 32'h08);
		`CHK(wake_irq, 1'b1)
		wr(off_h_flags, 32'h08);
		repeat (2) @(posedge clock);
		`CHK(wake_irq, 1'b0)
		// Bit six follows its pin, or only a start condition when selected
		wr(off_g_enables, 32'h40);
		pm.pulse(flag_six_pos, 6);
		rd(off_g_flags, 32'h40);
		wr(off_g_flags, 32'h40);
		wr(off_g_enables, 32'hc0);
		pm.pulse(flag_six_pos, 6);
		rd(off_g_flags, 32'h00);
		pm.start_cond();
		rd(off_g_flags, 32'h40);
		`CHK(wake_irq, 1'b1)
		wr(off_g_flags, 32'h40);
		wr(off_g_enables, 32'h00);
		// Stop: a short pulse is filtered out, a long one wakes
		wr(off_stop, 32'h1 << stop_bit);
		pm.pulse(11, filter_cycles - 1);
		repeat (4) @(posedge clock);
		`CHK(stop_mode, 1'b1)
		rd(off_h_flags, 32'h00);
		pm.pulse(11, filter_cycles);
		repeat (4) @(posedge clock);
		`CHK(stop_mode, 1'b0)
		`CHK(wake_irq, 1'b1)
		wr(off_h_flags, 32'h08);
		wr(off_stop, 32'h1 << wait_bit);
		@(posedge clock);
		`CHK(wait_mode, 1'b1)
		pm.pulse(11, 6);
		repeat (4) @(posedge clock);
		`CHK(wait_mode, 1'b0)
		wr(off_h_flags, 32'h08);
		// Sticky status, its mask, clear, and a refused write
		rd(off_irq_status, 32'h3);
		`CHK(event_irq, 1'b0)
		wr(off_irq_enable, 32'h1);
		@(posedge clock);
		`CHK(event_irq, 1'b1)
		wr(off_irq_clear, 32'h3);
		wr(off_irq_status, 32'h3);
		rd(off_irq_status, 32'h0);
		rd(off_irq_clear, 32'h0);
		`CHK(event_irq, 1'b0)
		// Unmapped address
		apb(1'b0, 8'h20, 32'h0);
		`CHK(e, 1'b1)
		summarize();
	end
endmodule
